/* File: hw/spirc_regs.sv */
// spi controller register map with received-character range comparator
// assumes a one-cycle strobe register port and a received-character pulse from the shifter
`timescale 1ns/1ps
`default_nettype none
`include "spirc_params.svh"

// How it works
// - writes to compare bounds are dropped while write protection is enabled
// - match flag sets when lower bound <= received character <= upper bound, unsigned
// - wakeup request raised on a match when partial wakeup is enabled
// - compare register holds lower bound in 15:0, upper bound in 31:16
// - one chip-select config register per select, at 0x30 plus n times 4
module spirc_regs
  import spirc_pkg::*;
#(
  parameter int NUM_CS = 4
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output var  logic [31:0] rdata,
  input  wire logic        rx_valid,
  input  wire logic [15:0] rx_char,
  input  wire logic        partial_wakeup_enable,
  output var  logic        wakeup_req,
  output var  logic        irq,
  output var  logic        evt_irq,
  output var  logic        reset_status_pulse
);

  spirc_word_type mode_r;
  spirc_word_type fifo_mode_r;
  spirc_word_type cmp_r;
  spirc_word_type wp_mode_r;
  spirc_word_type irq_mask_r;
  spirc_word_type cs_r [NUM_CS];
  logic [15:0]    rx_data_r;
  logic           rdrf_r;
  logic           compare_match_flag_r;
  logic           wpv_r;
  logic [1:0]     evt_status_r;
  logic [1:0]     evt_en_r;
  logic           hit;
  logic           rst_sta;
  logic           write_protect_enable;
  spirc_word_type status_flags;
  spirc_word_type rdata_nxt;

  assign write_protect_enable = wp_mode_r[`SPIRC_WP_EN_BIT];
  assign rst_sta = wr && addr == `SPIRC_OFS_CONTROL && wdata[`SPIRC_CTRL_RST_STA];
  // inclusive unsigned range
  assign hit = rx_valid
    && rx_char >= cmp_r[`SPIRC_CMP_LO_MSB:0]
    && rx_char <= cmp_r[`SPIRC_CMP_HI_MSB:`SPIRC_CMP_HI_LSB];

  always_comb
  begin
    status_flags = `SPIRC_RESET_WORD;
    status_flags[`SPIRC_SR_RDRF_BIT] = rdrf_r;
    status_flags[`SPIRC_SR_CMP_BIT] = compare_match_flag_r;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_r      <= `SPIRC_RESET_WORD;
      fifo_mode_r <= `SPIRC_RESET_WORD;
      wp_mode_r   <= `SPIRC_RESET_WORD;
    end
    else if (wr)
    begin
      if (addr == `SPIRC_OFS_MODE)
        mode_r <= wdata;
      if (addr == `SPIRC_OFS_FIFO_MODE)
        fifo_mode_r <= wdata;
      if (addr == `SPIRC_OFS_WP_MODE)
        wp_mode_r <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cmp_r <= `SPIRC_RESET_WORD;
    else if (wr && addr == `SPIRC_OFS_CMP && !write_protect_enable)
      cmp_r <= wdata;
  end

  // violation flag, read-clears; set wins
  always_ff @(posedge clk)
  begin
    if (rst)
      wpv_r <= 1'b0;
    else if (wr && addr == `SPIRC_OFS_CMP && write_protect_enable)
      wpv_r <= 1'b1;
    else if (rd && addr == `SPIRC_OFS_WP_STATUS)
      wpv_r <= 1'b0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CS; gi++)
    begin : g_cs
      always_ff @(posedge clk)
      begin
        if (rst)
          cs_r[gi] <= `SPIRC_RESET_WORD;
        else if (wr && addr == 8'(`SPIRC_OFS_CS_BASE + gi * `SPIRC_OFS_CS_STEP))
          cs_r[gi] <= wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_mask_r <= `SPIRC_RESET_WORD;
    else if (wr && addr == `SPIRC_OFS_IRQ_EN)
      irq_mask_r <= irq_mask_r | wdata;
    else if (wr && addr == `SPIRC_OFS_IRQ_DIS)
      irq_mask_r <= irq_mask_r & ~wdata;
  end

  // received data; read of data clears ready, new char wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_data_r <= '0;
      rdrf_r    <= 1'b0;
    end
    else if (rx_valid)
    begin
      rx_data_r <= rx_char;
      rdrf_r    <= 1'b1;
    end
    else if (rd && addr == `SPIRC_OFS_RXDATA)
      rdrf_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      compare_match_flag_r <= 1'b0;
    else if (hit)
      compare_match_flag_r <= 1'b1;
    else if (rst_sta)
      compare_match_flag_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wakeup_req <= 1'b0;
    else
      wakeup_req <= hit && partial_wakeup_enable;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      reset_status_pulse <= 1'b0;
    else
      reset_status_pulse <= rst_sta;
  end

  // sticky events, write-one-to-clear, set wins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      evt_status_r <= 2'b00;
      evt_en_r     <= 2'b00;
    end
    else
    begin
      if (wr && addr == `SPIRC_OFS_EVT_EN)
        evt_en_r <= wdata[1:0];
      evt_status_r[`SPIRC_EVT_CMP_BIT] <= hit
        || (evt_status_r[`SPIRC_EVT_CMP_BIT]
            && !(wr && addr == `SPIRC_OFS_EVT_CLR && wdata[`SPIRC_EVT_CMP_BIT]));
      evt_status_r[`SPIRC_EVT_WPV_BIT] <= (wr && addr == `SPIRC_OFS_CMP && write_protect_enable)
        || (evt_status_r[`SPIRC_EVT_WPV_BIT]
            && !(wr && addr == `SPIRC_OFS_EVT_CLR && wdata[`SPIRC_EVT_WPV_BIT]));
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq     <= 1'b0;
      evt_irq <= 1'b0;
    end
    else
    begin
      irq     <= |(status_flags & irq_mask_r);
      evt_irq <= |(evt_status_r & evt_en_r);
    end
  end

  always_comb
  begin
    rdata_nxt = `SPIRC_RESET_WORD;
    case (addr)
      `SPIRC_OFS_MODE:       rdata_nxt = mode_r;
      `SPIRC_OFS_RXDATA:     rdata_nxt = {16'h0000, rx_data_r};
      `SPIRC_OFS_STATUS:     rdata_nxt = status_flags;
      `SPIRC_OFS_IRQ_MASK:   rdata_nxt = irq_mask_r;
      `SPIRC_OFS_FIFO_MODE:  rdata_nxt = fifo_mode_r;
      `SPIRC_OFS_CMP:        rdata_nxt = cmp_r;
      `SPIRC_OFS_WP_MODE:    rdata_nxt = wp_mode_r;
      `SPIRC_OFS_WP_STATUS:  rdata_nxt = {31'h0000_0000, wpv_r};
      `SPIRC_OFS_EVT_STATUS: rdata_nxt = {30'h0000_0000, evt_status_r};
      `SPIRC_OFS_EVT_EN:     rdata_nxt = {30'h0000_0000, evt_en_r};
      default:               rdata_nxt = `SPIRC_RESET_WORD;
    endcase
    for (int i = 0; i < NUM_CS; i++)
      if (addr == 8'(`SPIRC_OFS_CS_BASE + i * `SPIRC_OFS_CS_STEP))
        rdata_nxt = cs_r[i];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= `SPIRC_RESET_WORD;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= `SPIRC_RESET_WORD;
  end

endmodule : spirc_regs
`default_nettype wire

/* File: shared/spirc_params.svh */
// register offsets, field positions, reset values for the spi register map block
// assumes inclusion by the design file; the package does not include it
`ifndef SPIRC_PARAMS_SVH
`define SPIRC_PARAMS_SVH
`define SPIRC_OFS_CONTROL     8'h00
`define SPIRC_OFS_MODE        8'h04
`define SPIRC_OFS_RXDATA      8'h08
`define SPIRC_OFS_TXDATA      8'h0C
`define SPIRC_OFS_STATUS      8'h10
`define SPIRC_OFS_IRQ_EN      8'h14
`define SPIRC_OFS_IRQ_DIS     8'h18
`define SPIRC_OFS_IRQ_MASK    8'h1C
`define SPIRC_OFS_CS_BASE     8'h30
`define SPIRC_OFS_CS_STEP     8'h04
`define SPIRC_OFS_FIFO_MODE   8'h40
`define SPIRC_OFS_FIFO_LEVEL  8'h44
`define SPIRC_OFS_CMP         8'h48
`define SPIRC_OFS_WP_MODE     8'hE4
`define SPIRC_OFS_WP_STATUS   8'hE8
`define SPIRC_OFS_EVT_STATUS  8'hF0
`define SPIRC_OFS_EVT_EN      8'hF4
`define SPIRC_OFS_EVT_CLR     8'hF8
`define SPIRC_CTRL_RST_STA    9
`define SPIRC_SR_CMP_BIT      11
`define SPIRC_SR_RDRF_BIT     0
`define SPIRC_WP_EN_BIT       0
`define SPIRC_CMP_LO_MSB      15
`define SPIRC_CMP_HI_LSB      16
`define SPIRC_CMP_HI_MSB      31
`define SPIRC_EVT_CMP_BIT     0
`define SPIRC_EVT_WPV_BIT     1
`define SPIRC_RESET_WORD      32'h0000_0000
`endif

/* File: shared/spirc_pkg.sv */
// types for the spi register map and receive compare block
// assumes spirc_params.svh sits beside it
package spirc_pkg;
  typedef logic [31:0] spirc_word_type;
  typedef logic [7:0]  spirc_addr_type;
endpackage : spirc_pkg

/* File: tb/spirc_props.sv */
// checker on the spirc_regs ports
// bound to every spirc_regs instance
`timescale 1ns/1ps
`default_nettype none
module spirc_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        rx_valid,
  input wire logic [15:0] rx_char,
  input wire logic        partial_wakeup_enable,
  input wire logic        wakeup_req,
  input wire logic        irq,
  input wire logic        evt_irq,
  input wire logic        reset_status_pulse
);
  logic        wp_r;
  logic [31:0] bnd_r;
  logic        hit;
  always_ff @(posedge clk)
  begin
    if (rst) wp_r <= 1'b0;
    else if (wr && addr == 8'hE4) wp_r <= wdata[0];
  end
  always_ff @(posedge clk)
  begin
    if (rst) bnd_r <= 32'h0000_0000;
    else if (wr && addr == 8'h48 && !wp_r) bnd_r <= wdata;
  end
  assign hit = rx_char >= bnd_r[15:0] && rx_char <= bnd_r[31:16];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_wake_hit; rx_valid && hit && partial_wakeup_enable |=> wakeup_req; endproperty
  property p_wake_src; wakeup_req |-> $past(rx_valid && hit && partial_wakeup_enable); endproperty
  property p_rd_idle; !$past(rd) |-> rdata == 32'h0000_0000; endproperty
  property p_sta; wr && addr == 8'h00 && wdata[9] |=> reset_status_pulse; endproperty
  property p_sta_src; reset_status_pulse |-> $past(wr && addr == 8'h00 && wdata[9]); endproperty
  property p_irq_up; $rose(irq) |-> $past(rx_valid || wr, 2); endproperty
  property p_evt_up; $rose(evt_irq) |-> $past(rx_valid || wr, 2); endproperty
  property p_mask_off; wr && addr == 8'h18 && wdata == 32'hFFFF_FFFF |-> ##2 !irq; endproperty
  a_wake_hit: assert property (p_wake_hit) else $error("wakeup missing");
  a_wake_src: assert property (p_wake_src) else $error("stray wakeup");
  a_rd_idle: assert property (p_rd_idle) else $error("rdata outside read");
  a_sta: assert property (p_sta) else $error("status reset missing");
  a_sta_src: assert property (p_sta_src) else $error("stray status reset");
  a_irq_up: assert property (p_irq_up) else $error("irq without cause");
  a_evt_up: assert property (p_evt_up) else $error("evt_irq without cause");
  a_mask_off: assert property (p_mask_off) else $error("irq after disable");
  c_wake: cover property (wakeup_req);
  c_irq: cover property ($rose(irq));
  c_evt: cover property ($rose(evt_irq));
endmodule : spirc_props
bind spirc_regs spirc_props spirc_props_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_valid,
  .rx_char, .partial_wakeup_enable, .wakeup_req, .irq, .evt_irq, .reset_status_pulse);
`default_nettype wire

/* File: tb/spirc_peer.sv */
// far side model: shifter handing received characters over
// assumes send is a one-cycle pulse from the bench
`timescale 1ns/1ps
`default_nettype none
module spirc_peer (
  input  wire logic        clk,
  input  wire logic        send,
  input  wire logic [15:0] char_in,
  output var  logic        rx_valid,
  output var  logic [15:0] rx_char
);
  initial
  begin
    rx_valid = 1'b0;
    rx_char = 16'h0000;
  end
  always @(posedge clk)
  begin
    rx_valid <= send;
    // idle line flips, stale values never look valid
    rx_char <= send ? char_in : ~rx_char;
  end
endmodule : spirc_peer
`default_nettype wire

/* File: tb/test_spirc_regs.sv */
// self-checking bench for spirc_regs
// assumes spirc_peer and spirc_props beside it
`timescale 1ns/1ps
`default_nettype none
module test_spirc_regs;
  import spirc_pkg::*;
  logic           clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, send = 1'b0, pwe = 1'b0;
  logic           rx_valid, wakeup_req, irq, evt_irq, rsp;
  logic [15:0]    char_in = 16'h0000, rx_char;
  spirc_addr_type addr = 8'h00;
  spirc_word_type wdata = 32'h0000_0000, rdata, v;
  int             n_mismatch = 0, tests_run = 0;
  spirc_addr_type ra [7] = '{8'h04, 8'h10, 8'h1C, 8'h30, 8'h44, 8'h48, 8'h20};
  logic [15:0]    rc [4] = '{16'h000F, 16'h0010, 16'h0020, 16'h0021};
  logic           re [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  always #5 clk = ~clk;
  spirc_regs spirc_regs_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_valid, .rx_char,
    .partial_wakeup_enable(pwe), .wakeup_req, .irq, .evt_irq, .reset_status_pulse(rsp));
  spirc_peer spirc_peer_inst (.clk, .send, .char_in, .rx_valid, .rx_char);
  task automatic chk(string s, spirc_word_type e, spirc_word_type g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wr_reg(spirc_addr_type a, spirc_word_type d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(spirc_addr_type a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic rx(logic [15:0] c, logic e);
    @(posedge clk);
    send <= 1'b1;
    char_in <= c;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1 chk("wakeup_req", e, wakeup_req);
  endtask : rx
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i])
    begin
      rd_reg(ra[i]);
      chk("reset value", 32'h0000_0000, v);
    end
    for (int n = 0; n < 4; n++) wr_reg(spirc_addr_type'(8'h30 + 4 * n), 32'hA5A5_0000 + n);
    for (int n = 0; n < 4; n++)
    begin
      rd_reg(spirc_addr_type'(8'h30 + 4 * n));
      chk("chip_select_config", 32'hA5A5_0000 + n, v);
    end
    wr_reg(8'h48, 32'h0020_0010);
    wr_reg(8'hE4, 32'h0000_0001);
    wr_reg(8'h48, 32'hFFFF_0000);
    rd_reg(8'h48);
    chk("rx_compare_bounds", 32'h0020_0010, v);
    rd_reg(8'hE8);
    chk("write_protect_status", 32'h0000_0001, v);
    rd_reg(8'hE8);
    chk("write_protect_status", 32'h0000_0000, v);
    wr_reg(8'hE4, 32'h0000_0000);
    pwe <= 1'b1;
    foreach (rc[i]) rx(rc[i], re[i]);
    pwe <= 1'b0;
    rx(16'h0018, 1'b0);
    rd_reg(8'h10);
    chk("compare_match_flag", 32'h0000_0800, v & 32'h0000_0800);
    wr_reg(8'h14, 32'h0000_0800);
    rd_reg(8'h1C);
    chk("irq_mask", 32'h0000_0800, v);
    chk("irq", 1, irq);
    wr_reg(8'h18, 32'hFFFF_FFFF);
    rd_reg(8'h1C);
    chk("irq_mask", 32'h0000_0000, v);
    chk("irq", 0, irq);
    wr_reg(8'hF4, 32'h0000_0001);
    rd_reg(8'hF0);
    chk("evt_status", 32'h0000_0003, v);
    chk("evt_irq", 1, evt_irq);
    wr_reg(8'hF8, 32'h0000_0001);
    wr_reg(8'h00, 32'h0000_0200);
    #1 chk("reset_status_pulse", 1, rsp);
    rd_reg(8'h10);
    chk("compare_match_flag", 32'h0000_0000, v & 32'h0000_0800);
    chk("evt_irq", 0, evt_irq);
    rd_reg(8'hF0);
    chk("evt_status", 32'h0000_0002, v);
    print_verdict;
  end
endmodule : test_spirc_regs
`default_nettype wire
